// [core/msad_decoder.sv]
/*
  memory space address decoder: routes fetch and data requests to targets.
  assumes requests from logic on i_clk and a single system clock.
*/
// Contract
// - space is 256 segments of 64 KB, four 16 KB pages each.
// - every location takes byte and word accesses.
// - dual-port RAM is 2 KB from 00'F600.
// - top 256 bytes of dual-port RAM are bit addressable.
// - bank holds 16 words or byte halves; bank locations are bit addressable (code sets o_da_bit_ok for them only while the bank lies in dual-port RAM).
// - reserved areas become external bus cycles where that bus exists.
// - no pipeline optimisation for 21'0000 to 3F'FFFF.
// - data memories and both register areas sit in segment 0.
// - all fetches go through the program-side memory unit.
// - all data transfers go through the data-side memory unit.
// - cross-unit cases go over the system bus.
// - system bus carries both directions at once.
// - program SRAM from E0'0000 with programmable write-protected part.
// - data SRAM from 00'A000 on its own interface.
// - two 512-byte register areas, registers word wide.
// - flash module 0 from C0'0000, modules up to 256 KB.
// - flash modules split into 4 KB sectors.
// - sectors write protected singly; programming in 128-byte blocks.
// - sector at C0'F000 is kept for internal use.
// - flash read protectable; password sequence lifts protection.
// - flash reads 128-bit lines; different modules work in parallel.
`include "msad_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module msad_decoder (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  // configuration
  input  wire logic                    i_has_ebus,
  input  wire logic [15:0]             i_program_sram_wp_size,
  input  wire logic [`MSAD_SECT_NUM-1:0] i_flash_sect_wp,
  input  wire logic                    i_flash_rd_prot,
  input  wire logic [31:0]             i_flash_password,
  input  wire logic                    i_flash_relock,
  // instruction fetch request
  input  wire logic                    i_if_req,
  input  wire logic [23:0]             i_if_addr,
  // data request
  input  wire logic                    i_da_req,
  input  wire logic [23:0]             i_da_addr,
  input  wire logic                    i_da_we,
  input  wire logic                    i_da_byte,
  input  wire logic [15:0]             i_da_wdata,
  input  wire logic                    i_da_gpr,
  input  wire logic [3:0]              i_da_gpr_idx,
  input  wire logic [15:0]             i_da_cp,
  // fetch route
  output logic                         o_if_valid,
  output msad_pkg::msad_tgt_t          o_if_tgt,
  output logic [23:0]                  o_if_off,
  output logic                         o_if_sysbus,
  output logic                         o_if_nopipe,
  output logic                         o_if_trap,
  // data route
  output logic                         o_da_valid,
  output msad_pkg::msad_tgt_t          o_da_tgt,
  output logic [23:0]                  o_da_off,
  output logic                         o_da_we,
  output logic [1:0]                   o_da_be,
  output logic [15:0]                  o_da_wdata,
  output logic                         o_da_sysbus,
  output logic                         o_da_nopipe,
  output logic                         o_da_trap,
  output logic                         o_da_wr_blk,
  output logic                         o_da_rd_blk,
  output logic                         o_da_bit_ok,
  // flash side
  output logic [7:0]                   o_da_sector,
  output logic [4:0]                   o_da_block,
  output logic [19:0]                  o_da_line,
  output logic                         o_flash_par,
  output logic                         o_flash_unlocked
);
  import msad_pkg::*;

  msad_state_t q_q;
  msad_state_t d_d;

  msad_tgt_t   if_tgt;
  logic [23:0] if_off;
  logic [1:0]  if_fmod;
  logic        if_rsv;
  logic        if_extio;
  msad_tgt_t   da_tgt;
  logic [23:0] da_off;
  logic [1:0]  da_fmod;
  logic        da_rsv;
  logic        da_extio;
  logic [23:0] da_ea;
  logic [15:0] gpr_ofs;
  logic [7:0]  sect_idx;
  logic        sect_wp;
  logic        if_prog;
  logic        da_local;
  logic        da_flash;
  logic        da_dpr_top;
  logic        pw_hit;

  // bank registers: words at cp+2n, byte halves at cp+n
  assign gpr_ofs = i_da_byte ? {12'h000, i_da_gpr_idx}
                             : {11'h000, i_da_gpr_idx, 1'b0};
  // bank registers always live in segment 0
  assign da_ea = i_da_gpr ? {8'h00, i_da_cp + gpr_ofs} : i_da_addr;

  // full 24-bit decode; segment and page fall out of the address bits
  msad_region_decode u_if_dec (
    .i_addr     (i_if_addr),
    .i_has_ebus (i_has_ebus),
    .o_tgt      (if_tgt),
    .o_off      (if_off),
    .o_fmod     (if_fmod),
    .o_rsv      (if_rsv),
    .o_extio    (if_extio)
  );

  msad_region_decode u_da_dec (
    .i_addr     (da_ea),
    .i_has_ebus (i_has_ebus),
    .o_tgt      (da_tgt),
    .o_off      (da_off),
    .o_fmod     (da_fmod),
    .o_rsv      (da_rsv),
    .o_extio    (da_extio)
  );

  // flash sectors numbered 64 per module; module 3 has only 16
  assign sect_idx = {da_fmod, da_off[`MSAD_FMOD_OFF_W-1:`MSAD_SECT_LSB]};

  always_comb begin
    sect_wp = 1'b0;
    if (sect_idx < 8'(`MSAD_SECT_NUM)) begin
      sect_wp = i_flash_sect_wp[sect_idx];
    end
  end

  // program memories are the only targets the fetch unit owns
  assign if_prog = (if_tgt == TGT_FLASH) || (if_tgt == TGT_PROGRAM_SRAM) ||
                   (if_tgt == TGT_EMULATED_PROGRAM_SRAM);
  // data unit owns data sram, dual-port ram and register areas
  assign da_local = (da_tgt == TGT_DATA_SRAM) || (da_tgt == TGT_DUAL_PORT_RAM) ||
                    (da_tgt == TGT_SFR) || (da_tgt == TGT_EXTENDED_FUNCTION_REGISTER_AREA) ||
                    (da_tgt == TGT_IMB);
  assign da_flash = (da_tgt == TGT_FLASH);
  assign da_dpr_top = (da_ea >= `MSAD_DUAL_PORT_RAM_BIT) && (da_ea < `MSAD_SFR_BASE);
  // password is two word writes to the flash base, low half first
  assign pw_hit = i_da_req && i_da_we && !i_da_byte && !i_da_gpr &&
                  (i_da_addr == `MSAD_PW_ADDR);

  always_comb begin
    d_d = q_q;

    // fetch path, independent of the data path in every cycle
    d_d.if_valid  = i_if_req;
    d_d.if_tgt    = if_tgt;
    d_d.if_off    = if_off;
    // non-program fetches reach the data side over the system bus
    d_d.if_sysbus = i_if_req && !if_prog && (if_tgt != TGT_TRAP);
    d_d.if_nopipe = i_if_req && if_extio;
    d_d.if_trap   = i_if_req && (if_tgt == TGT_TRAP);

    // data path
    d_d.da_valid  = i_da_req;
    d_d.da_tgt    = da_tgt;
    d_d.da_off    = da_off;
    d_d.da_we     = i_da_req && i_da_we;
    d_d.da_wdata  = i_da_wdata;
    // byte lane from address bit 0, word takes both lanes
    if (i_da_byte) begin
      d_d.da_be = da_ea[0] ? 2'b10 : 2'b01;
    end else begin
      d_d.da_be = 2'b11;
    end
    // register areas are word wide; a byte write still lands in one lane
    if ((da_tgt == TGT_SFR) || (da_tgt == TGT_EXTENDED_FUNCTION_REGISTER_AREA)) begin
      d_d.da_off = {da_off[23:1], 1'b0};
    end
    // operands from program memory, program_sram writes, external and bus targets
    d_d.da_sysbus = i_da_req && !da_local && (da_tgt != TGT_TRAP);
    d_d.da_nopipe = i_da_req && da_extio;
    d_d.da_trap   = i_da_req && (da_tgt == TGT_TRAP);

    // write protection
    d_d.da_wr_blk = 1'b0;
    if (i_da_req && i_da_we) begin
      if ((da_tgt == TGT_PROGRAM_SRAM) && (da_off[15:0] < i_program_sram_wp_size)) begin
        d_d.da_wr_blk = 1'b1;
      end else if (da_flash && (da_fmod == 2'b00) &&
                   (da_off[`MSAD_FMOD_OFF_W-1:`MSAD_SECT_LSB] == 6'(`MSAD_CTRL_SECT))) begin
        d_d.da_wr_blk = 1'b1;
      end else if (da_flash && sect_wp && !q_q.unlocked) begin
        d_d.da_wr_blk = 1'b1;
      end else if (pw_hit) begin
        // password words are consumed, never written to the array
        d_d.da_wr_blk = 1'b1;
      end
    end

    // read protection of the whole flash area
    d_d.da_rd_blk = i_da_req && !i_da_we && da_flash &&
                    i_flash_rd_prot && !q_q.unlocked;

    // bit access: top 256 bytes of dual-port ram, or a bank location inside dual-port ram
    d_d.da_bit_ok = i_da_req && (da_tgt == TGT_DUAL_PORT_RAM) &&
                    (da_dpr_top || i_da_gpr);

    // flash geometry
    d_d.da_sector = sect_idx;
    d_d.da_block  = da_off[`MSAD_SECT_LSB-1:`MSAD_BLK_LSB];
    // one 128-bit line per access
    d_d.da_line   = da_off[`MSAD_ADDR_W-1:`MSAD_LINE_LSB];
    // both units in flash but different modules run side by side
    d_d.flash_par = i_if_req && i_da_req && (if_tgt == TGT_FLASH) &&
                    da_flash && (if_fmod != da_fmod);

    // password sequence; relock loses against a completing unlock
    case (q_q.pw_st)
      PW_IDLE: begin
        if (pw_hit && (i_da_wdata == i_flash_password[15:0])) begin
          d_d.pw_st = PW_HALF;
        end
      end
      PW_HALF: begin
        // any other data access aborts the sequence
        d_d.pw_st = PW_IDLE;
        if (!i_da_req) begin
          d_d.pw_st = PW_HALF;
        end else if (pw_hit && (i_da_wdata == i_flash_password[31:16])) begin
          d_d.unlocked = 1'b1;
        end
      end
      default: begin
        d_d.pw_st = PW_IDLE;
      end
    endcase
    if (i_flash_relock && !(d_d.unlocked && !q_q.unlocked)) begin
      d_d.unlocked = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q_q <= '0;
    end else begin
      q_q <= d_d;
    end
  end

  // registered outputs
  assign o_if_valid       = q_q.if_valid;
  assign o_if_tgt         = q_q.if_tgt;
  assign o_if_off         = q_q.if_off;
  assign o_if_sysbus      = q_q.if_sysbus;
  assign o_if_nopipe      = q_q.if_nopipe;
  assign o_if_trap        = q_q.if_trap;
  assign o_da_valid       = q_q.da_valid;
  assign o_da_tgt         = q_q.da_tgt;
  assign o_da_off         = q_q.da_off;
  assign o_da_we          = q_q.da_we;
  assign o_da_be          = q_q.da_be;
  assign o_da_wdata       = q_q.da_wdata;
  assign o_da_sysbus      = q_q.da_sysbus;
  assign o_da_nopipe      = q_q.da_nopipe;
  assign o_da_trap        = q_q.da_trap;
  assign o_da_wr_blk      = q_q.da_wr_blk;
  assign o_da_rd_blk      = q_q.da_rd_blk;
  assign o_da_bit_ok      = q_q.da_bit_ok;
  assign o_da_sector      = q_q.da_sector;
  assign o_da_block       = q_q.da_block;
  assign o_da_line        = q_q.da_line;
  assign o_flash_par      = q_q.flash_par;
  assign o_flash_unlocked = q_q.unlocked;
endmodule : msad_decoder
`default_nettype wire

// [core/msad_region_decode.sv]
/*
  combinational region decode of one 24-bit address.
  assumes the caller registers the results.
*/
`include "msad_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module msad_region_decode (
  // address in
  input  wire logic [23:0]       i_addr,
  input  wire logic              i_has_ebus,
  // decode out
  output msad_pkg::msad_tgt_t    o_tgt,
  output logic [23:0]            o_off,
  output logic [1:0]             o_fmod,
  output logic                   o_rsv,
  output logic                   o_extio
);
  import msad_pkg::*;
  logic [23:0] a;
  msad_tgt_t   rsv_tgt;
  assign a = i_addr;
  // reserved holes go out as external cycles only where a bus exists
  assign rsv_tgt = i_has_ebus ? TGT_EXT : TGT_TRAP;
  assign o_fmod = a[19:18];
  assign o_extio = (a >= `MSAD_EXTIO_BASE) && (a <= `MSAD_EXTIO_END);
  always_comb begin
    o_rsv = 1'b0;
    o_off = a;
    o_tgt = TGT_EXT;
    if (a >= `MSAD_IMB_BASE) begin
      o_tgt = TGT_IMB;
      o_off = a - `MSAD_IMB_BASE;
    end else if (a >= `MSAD_TRAP_BASE) begin
      o_tgt = TGT_TRAP;
    end else if (a >= `MSAD_EMULATED_PROGRAM_SRAM_BASE) begin
      o_tgt = TGT_EMULATED_PROGRAM_SRAM;
      o_off = {9'h000, a[`MSAD_MIRROR_W-1:0]};
    end else if (a >= `MSAD_PROGRAM_SRAM_BASE) begin
      o_tgt = TGT_PROGRAM_SRAM;
      o_off = {9'h000, a[`MSAD_MIRROR_W-1:0]};
    end else if (a >= `MSAD_FRSV_BASE) begin
      o_tgt = rsv_tgt;
      o_rsv = 1'b1;
    end else if (a >= `MSAD_FLASH_BASE) begin
      o_tgt = TGT_FLASH;
      o_off = {6'h00, a[`MSAD_FMOD_OFF_W-1:0]};
    end else if (a >= `MSAD_LXRSV2_BASE && a < `MSAD_EXTIO_BASE) begin
      o_tgt = rsv_tgt;
      o_rsv = 1'b1;
    end else if (a >= `MSAD_LXALT_BASE && a < `MSAD_EXTIO_BASE) begin
      o_tgt = TGT_INTERNAL_PERIPHERAL_BUS;
    end else if (a >= `MSAD_LXRSV1_BASE && a < `MSAD_EXTIO_BASE) begin
      o_tgt = rsv_tgt;
      o_rsv = 1'b1;
    end else if (a >= `MSAD_LX_BASE && a < `MSAD_EXTIO_BASE) begin
      o_tgt = TGT_INTERNAL_PERIPHERAL_BUS;
    end else if (a >= `MSAD_EXT1_BASE) begin
      o_tgt = TGT_EXT;
    end else if (a >= `MSAD_SFR_BASE) begin
      o_tgt = TGT_SFR;
      o_off = a - `MSAD_SFR_BASE;
    end else if (a >= `MSAD_DUAL_PORT_RAM_BASE) begin
      o_tgt = TGT_DUAL_PORT_RAM;
      o_off = a - `MSAD_DUAL_PORT_RAM_BASE;
    end else if (a >= `MSAD_DPRSV_BASE) begin
      o_tgt = rsv_tgt;
      o_rsv = 1'b1;
    end else if (a >= `MSAD_EXTENDED_FUNCTION_REGISTER_AREA_BASE) begin
      o_tgt = TGT_EXTENDED_FUNCTION_REGISTER_AREA;
      o_off = a - `MSAD_EXTENDED_FUNCTION_REGISTER_AREA_BASE;
    end else if (a >= `MSAD_EXTERNAL_FUNCTION_REGISTER_AREA_BASE) begin
      o_tgt = TGT_EXTERNAL_FUNCTION_REGISTER_AREA;
      o_off = a - `MSAD_EXTERNAL_FUNCTION_REGISTER_AREA_BASE;
    end else if (a >= `MSAD_DATA_SRAM_BASE) begin
      o_tgt = TGT_DATA_SRAM;
      o_off = a - `MSAD_DATA_SRAM_BASE;
    end else if (a >= `MSAD_DSRSV_BASE) begin
      o_tgt = rsv_tgt;
      o_rsv = 1'b1;
    end
  end
endmodule : msad_region_decode
`default_nettype wire

// [inc/msad_defs.svh]
/*
  address map constants of the memory space address decoder.
  assumes a 24-bit byte address and 16-bit data.
*/
`ifndef MSAD_DEFS_SVH
`define MSAD_DEFS_SVH
`define MSAD_ADDR_W      24
`define MSAD_SEG_LSB     16
`define MSAD_PAGE_LSB    14
`define MSAD_IMB_BASE    24'hffff00
`define MSAD_TRAP_BASE   24'hf00000
`define MSAD_EPMIR_BASE  24'he88000
`define MSAD_EMULATED_PROGRAM_SRAM_BASE 24'he80000
`define MSAD_PMIR_BASE   24'he08000
`define MSAD_PROGRAM_SRAM_BASE  24'he00000
`define MSAD_FRSV_BASE   24'hcd0000
`define MSAD_FLASH_BASE  24'hc00000
`define MSAD_EXT2_BASE   24'h400000
`define MSAD_EXTIO_BASE  24'h210000
`define MSAD_EXTIO_END   24'h3fffff
`define MSAD_LXRSV2_BASE 24'h20bc00
`define MSAD_LXALT_BASE  24'h208000
`define MSAD_LXRSV1_BASE 24'h206000
`define MSAD_LX_BASE     24'h200000
`define MSAD_EXT1_BASE   24'h010000
`define MSAD_SFR_BASE    24'h00fe00
`define MSAD_DUAL_PORT_RAM_BASE  24'h00f600
`define MSAD_DUAL_PORT_RAM_BIT   24'h00fd00
`define MSAD_DPRSV_BASE  24'h00f200
`define MSAD_EXTENDED_FUNCTION_REGISTER_AREA_BASE   24'h00f000
`define MSAD_EXTERNAL_FUNCTION_REGISTER_AREA_BASE   24'h00e000
`define MSAD_DATA_SRAM_BASE  24'h00a000
`define MSAD_DSRSV_BASE  24'h008000
`define MSAD_MIRROR_W    15
`define MSAD_FMOD_OFF_W  18
`define MSAD_SECT_LSB    12
`define MSAD_BLK_LSB     7
`define MSAD_LINE_LSB    4
`define MSAD_SECT_NUM    208
`define MSAD_CTRL_SECT   8'h0f
`define MSAD_PW_ADDR     24'hc00000
`endif

// [inc/msad_pkg.sv]
/*
  types of the memory space address decoder.
  assumes msad_defs.svh for the numeric constants.
*/
package msad_pkg;
  typedef enum logic [3:0] {
    TGT_EXT, TGT_INTERNAL_PERIPHERAL_BUS, TGT_FLASH, TGT_PROGRAM_SRAM, TGT_EMULATED_PROGRAM_SRAM, TGT_DATA_SRAM,
    TGT_DUAL_PORT_RAM, TGT_SFR, TGT_EXTENDED_FUNCTION_REGISTER_AREA, TGT_EXTERNAL_FUNCTION_REGISTER_AREA, TGT_IMB, TGT_TRAP
  } msad_tgt_t;
  typedef enum logic [0:0] {PW_IDLE, PW_HALF} msad_pw_t;
  typedef struct packed {
    logic        if_valid;
    msad_tgt_t   if_tgt;
    logic [23:0] if_off;
    logic        if_sysbus;
    logic        if_nopipe;
    logic        if_trap;
    logic        da_valid;
    msad_tgt_t   da_tgt;
    logic [23:0] da_off;
    logic        da_we;
    logic [1:0]  da_be;
    logic [15:0] da_wdata;
    logic        da_sysbus;
    logic        da_nopipe;
    logic        da_trap;
    logic        da_wr_blk;
    logic        da_rd_blk;
    logic        da_bit_ok;
    logic [7:0]  da_sector;
    logic [4:0]  da_block;
    logic [19:0] da_line;
    logic        flash_par;
    logic        unlocked;
    msad_pw_t    pw_st;
  } msad_state_t;
endpackage : msad_pkg

// [sim/msad_cpu_model.sv]
/*
  model of the cpu fetch and data request ports.
  assumes the decoder takes requests on every rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module msad_cpu_model (
  // clock
  input  wire logic   i_clk,
  // fetch request
  output logic        o_if_req,
  output logic [23:0] o_if_addr,
  // data request
  output logic        o_da_req,
  output logic [23:0] o_da_addr,
  output logic        o_da_we,
  output logic        o_da_byte,
  output logic [15:0] o_da_wdata
);
  initial begin
    o_if_req = 1'b0;
    o_if_addr = 24'h000000;
    o_da_req = 1'b0;
    o_da_addr = 24'h000000;
    o_da_we = 1'b0;
    o_da_byte = 1'b0;
    o_da_wdata = 16'h0000;
  end
  // released lines flip so a stale value never looks valid
  task automatic go(input logic fr, input logic [23:0] fa, input logic dr,
                    input logic [23:0] da, input logic we, input logic by,
                    input logic [15:0] wd);
    @(negedge i_clk);
    o_if_req = fr;
    o_if_addr = fr ? fa : ~o_if_addr;
    o_da_req = dr;
    o_da_addr = dr ? da : ~o_da_addr;
    o_da_we = dr & we;
    o_da_byte = by;
    o_da_wdata = dr ? wd : ~o_da_wdata; // write data flips too while no data request is made
    @(posedge i_clk);
    #1;
  endtask : go
  task automatic idle();
    go(1'b0, 24'h000000, 1'b0, 24'h000000, 1'b0, 1'b0, 16'h0000);
  endtask : idle
endmodule : msad_cpu_model
`default_nettype wire

// [sim/msad_decoder_asserts.sv]
/*
  concurrent checks on the address decoder ports.
  assumes binding into msad_decoder, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module msad_decoder_asserts
  import msad_pkg::*;
(
  // clock and reset
  input wire logic                i_clk,
  input wire logic                i_rst,
  // requests
  input wire logic                i_if_req,
  input wire logic [23:0]         i_if_addr,
  input wire logic                i_da_req,
  input wire logic [23:0]         i_da_addr,
  input wire logic                i_da_byte,
  input wire logic                i_da_gpr,
  // routes
  input wire logic                o_if_valid,
  input wire msad_pkg::msad_tgt_t o_if_tgt,
  input wire logic [23:0]         o_if_off,
  input wire logic                o_if_trap,
  input wire logic                o_da_valid,
  input wire msad_pkg::msad_tgt_t o_da_tgt,
  input wire logic [23:0]         o_da_off,
  input wire logic [1:0]          o_da_be,
  input wire logic                o_da_nopipe,
  input wire logic                o_da_sysbus,
  input wire logic                o_da_bit_ok
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_if_valid;
    i_if_req |=> o_if_valid;
  endproperty
  a_if_valid: assert property (p_if_valid) else $error("fetch not routed");
  property p_da_idle;
    !i_da_req [*2] |=> !o_da_valid;
  endproperty
  a_da_idle: assert property (p_da_idle) else $error("data valid without request");
  property p_be_odd;
    i_da_req && i_da_byte && i_da_addr[0] |=> o_da_be == 2'h2;
  endproperty
  a_be_odd: assert property (p_be_odd) else $error("odd byte lane wrong");
  property p_nopipe;
    i_da_req |=> o_da_nopipe == ($past(i_da_addr) inside {[24'h210000:24'h3fffff]});
  endproperty
  a_nopipe: assert property (p_nopipe) else $error("pipeline flag wrong");
  property p_trap;
    i_if_req && i_if_addr >= 24'hf00000 && i_if_addr < 24'hffff00 |=> o_if_trap;
  endproperty
  a_trap: assert property (p_trap) else $error("reserved fetch not trapped");
  property p_dual_port_ram;
    i_da_req && i_da_addr inside {[24'h00f600:24'h00fdff]} |=>
      o_da_tgt == TGT_DUAL_PORT_RAM && o_da_off == $past(i_da_addr) - 24'h00f600;
  endproperty
  a_dual_port_ram: assert property (p_dual_port_ram) else $error("dual port ram decode wrong");
  property p_bit;
    i_da_req && !i_da_gpr && i_da_addr inside {[24'h00fd00:24'h00fdff]} |=> o_da_bit_ok;
  endproperty
  a_bit: assert property (p_bit) else $error("top ram bytes not bit addressable");
  property p_program_sram;
    i_if_req && i_if_addr[23:19] == 5'h1c |=>
      o_if_tgt == TGT_PROGRAM_SRAM && o_if_off == ($past(i_if_addr) & 24'h007fff);
  endproperty
  a_program_sram: assert property (p_program_sram) else $error("program sram alias wrong");
  property p_seg0;
    i_da_req && i_da_addr[23:16] != 8'h00 |=>
      !(o_da_tgt inside {TGT_DATA_SRAM, TGT_DUAL_PORT_RAM, TGT_SFR, TGT_EXTENDED_FUNCTION_REGISTER_AREA});
  endproperty
  a_seg0: assert property (p_seg0) else $error("internal ram outside segment 0");
  property p_data_sram;
    i_da_req && i_da_addr inside {[24'h00a000:24'h00dfff]} |=>
      o_da_tgt == TGT_DATA_SRAM && !o_da_sysbus;
  endproperty
  a_data_sram: assert property (p_data_sram) else $error("data sram path wrong");
endmodule : msad_decoder_asserts

bind msad_decoder msad_decoder_asserts i_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_if_req(i_if_req), .i_if_addr(i_if_addr),
  .i_da_req(i_da_req), .i_da_addr(i_da_addr), .i_da_byte(i_da_byte),
  .i_da_gpr(i_da_gpr), .o_if_valid(o_if_valid), .o_if_tgt(o_if_tgt),
  .o_if_off(o_if_off), .o_if_trap(o_if_trap), .o_da_valid(o_da_valid),
  .o_da_tgt(o_da_tgt), .o_da_off(o_da_off), .o_da_be(o_da_be),
  .o_da_nopipe(o_da_nopipe), .o_da_sysbus(o_da_sysbus), .o_da_bit_ok(o_da_bit_ok)
);
`default_nettype wire

// [sim/tb.sv]
/*
  testbench of the address decoder: map, lanes, protection, unlock.
  assumes msad_cpu_model drives the requests, bank access from cp and index.
*/
`include "msad_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msad_pkg::*;
  logic clk, rst, ebus, rdp, rlk, ifr, dar, dwe, dby, ifv, ifx, dav, dtr;
  logic wbk, rbk, par, unl, bank_register, ifs, ifn, dwr, bok;
  logic [15:0] wps, dwd, cp, dwo;
  logic [3:0] gix;
  logic [`MSAD_SECT_NUM-1:0] swp;
  logic [31:0] pw;
  logic [23:0] ifa, daa, if_off, da_off;
  msad_tgt_t if_tgt, da_tgt;
  logic [1:0] be;
  logic [7:0] sec;
  logic [4:0] blk;
  logic [19:0] line;
  int n_errors, n_checks;

  msad_decoder i_dut (
    .i_clk(clk), .i_rst(rst), .i_has_ebus(ebus), .i_program_sram_wp_size(wps),
    .i_flash_sect_wp(swp), .i_flash_rd_prot(rdp), .i_flash_password(pw),
    .i_flash_relock(rlk), .i_if_req(ifr), .i_if_addr(ifa), .i_da_req(dar),
    .i_da_addr(daa), .i_da_we(dwe), .i_da_byte(dby), .i_da_wdata(dwd),
    .i_da_gpr(bank_register), .i_da_gpr_idx(gix), .i_da_cp(cp),
    .o_if_valid(ifv), .o_if_tgt(if_tgt), .o_if_off(if_off), .o_if_sysbus(ifs),
    .o_if_nopipe(ifn), .o_if_trap(ifx), .o_da_valid(dav), .o_da_tgt(da_tgt),
    .o_da_off(da_off), .o_da_we(dwr), .o_da_be(be), .o_da_wdata(dwo), .o_da_sysbus(),
    .o_da_nopipe(), .o_da_trap(dtr), .o_da_wr_blk(wbk), .o_da_rd_blk(rbk),
    .o_da_bit_ok(bok), .o_da_sector(sec), .o_da_block(blk), .o_da_line(line),
    .o_flash_par(par), .o_flash_unlocked(unl)
  );
  msad_cpu_model i_cpu (
    .i_clk(clk), .o_if_req(ifr), .o_if_addr(ifa), .o_da_req(dar),
    .o_da_addr(daa), .o_da_we(dwe), .o_da_byte(dby), .o_da_wdata(dwd)
  );

  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // data-only request, read or write, cheapest request form
  task automatic dr(input logic [23:0] a, input logic we, input logic by,
                    input logic [15:0] wd);
    i_cpu.go(1'b0, 24'h000000, 1'b1, a, we, by, wd);
  endtask : dr

  task automatic t_map();
    logic [23:0] a[13] = '{24'h00f650, 24'h00fd10, 24'h00a010, 24'h00fe02, 24'h00f004,
      24'h00e010, 24'he08100, 24'he88010, 24'hc41000, 24'hffff00, 24'hf00000,
      24'h206000, 24'h210000};
    msad_tgt_t t[13] = '{TGT_DUAL_PORT_RAM, TGT_DUAL_PORT_RAM, TGT_DATA_SRAM, TGT_SFR, TGT_EXTENDED_FUNCTION_REGISTER_AREA,
      TGT_EXTERNAL_FUNCTION_REGISTER_AREA, TGT_PROGRAM_SRAM, TGT_EMULATED_PROGRAM_SRAM, TGT_FLASH, TGT_IMB, TGT_TRAP, TGT_EXT, TGT_EXT};
    logic [23:0] o[13] = '{24'h50, 24'h710, 24'h10, 24'h2, 24'h4, '1, 24'h100,
      24'h10, 24'h1000, '1, '1, '1, '1};
    for (int k = 0; k < 13; k++) begin
      i_cpu.go(1'b1, a[k], 1'b1, a[k], 1'b0, 1'b0, 16'h0000);
      chk(da_tgt, t[k]);
      chk(if_tgt, t[k]);
      if (o[k] != '1) chk(da_off, o[k]);
      if (o[k] != '1) chk(if_off, o[k]);
      chk(ifx, t[k] == TGT_TRAP);
    end
    // last entry is an external io fetch, still standing
    chk(ifs, 1'b1);
    chk(ifn, 1'b1);
    chk(ifv, 1'b1);
    chk(dav, 1'b1);
  endtask : t_map
  task automatic t_ebus();
    ebus = 1'b0;
    dr(24'h206000, 1'b0, 1'b0, 16'h0000);
    chk(dtr, 1'b1);
    dr(24'h008000, 1'b0, 1'b0, 16'h0000);
    chk(da_tgt, TGT_TRAP);
    ebus = 1'b1;
  endtask : t_ebus
  task automatic t_be();
    dr(24'h00a001, 1'b1, 1'b1, 16'h00a5);
    chk(be, 2'h2);
    dr(24'h00a000, 1'b1, 1'b1, 16'h005a);
    chk(be, 2'h1);
    dr(24'h00a000, 1'b1, 1'b0, 16'h1234);
    chk(be, 2'h3);
    chk(dwr, 1'b1);
    chk(dwo, 16'h1234);
  endtask : t_be
  task automatic t_prot();
    wps = 16'h0100;
    swp[65] = 1'b1;
    dr(24'he000fe, 1'b1, 1'b0, 16'h1111);
    chk(wbk, 1'b1);
    dr(24'he00100, 1'b1, 1'b0, 16'h1111);
    chk(wbk, 1'b0);
    dr(24'hc41080, 1'b1, 1'b0, 16'h2222);
    chk(wbk, 1'b1);
    chk(sec, 8'h41);
    chk(blk, 5'h01);
    chk(line, 20'h00108);
    dr(24'hc42000, 1'b1, 1'b0, 16'h2222);
    chk(wbk, 1'b0);
    dr(24'hc0f010, 1'b1, 1'b0, 16'h2222);
    chk(wbk, 1'b1);
    dr(24'hc1f010, 1'b1, 1'b0, 16'h2222);
    chk(wbk, 1'b0);
    wps = 16'h0000;
    swp = '0;
  endtask : t_prot
  task automatic t_par();
    i_cpu.go(1'b1, 24'hc00000, 1'b1, 24'hc40000, 1'b0, 1'b0, 16'h0000);
    chk(par, 1'b1);
    chk(ifs, 1'b0);
    i_cpu.go(1'b1, 24'hc00000, 1'b1, 24'hc00010, 1'b0, 1'b0, 16'h0000);
    chk(par, 1'b0);
  endtask : t_par
  task automatic t_pw();
    rdp = 1'b1;
    dr(24'hc00010, 1'b0, 1'b0, 16'h0000);
    chk(rbk, 1'b1);
    dr(24'hc00000, 1'b1, 1'b0, pw[15:0]);
    chk(wbk, 1'b1);
    dr(24'hc00000, 1'b1, 1'b0, pw[31:16]);
    i_cpu.idle();
    chk(unl, 1'b1);
    dr(24'hc00010, 1'b0, 1'b0, 16'h0000);
    chk(rbk, 1'b0);
    rlk = 1'b1;
    i_cpu.idle();
    rlk = 1'b0;
    chk(unl, 1'b0);
    rdp = 1'b0;
  endtask : t_pw
  // bank access: address comes from cp and index, not from the bus
  task automatic t_gpr();
    bank_register = 1'b1;
    cp = 16'hfc00;
    gix = 4'h3;
    dr(24'h000000, 1'b0, 1'b0, 16'h0000);
    chk(da_tgt, TGT_DUAL_PORT_RAM);
    chk(da_off, 24'h000606);
    chk(bok, 1'b1);
    gix = 4'h5;
    dr(24'h000000, 1'b0, 1'b1, 16'h0000);
    chk(da_off, 24'h000605);
    chk(be, 2'h2);
    bank_register = 1'b0;
    dr(24'h00fc06, 1'b0, 1'b0, 16'h0000);
    chk(bok, 1'b0);
    dr(24'h00fd06, 1'b0, 1'b0, 16'h0000);
    chk(bok, 1'b1);
  endtask : t_gpr

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the real run length
  initial begin
    #1000000;
    n_errors++;
    results();
  end
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst = 1'b1;
    ebus = 1'b1;
    rdp = 1'b0;
    rlk = 1'b0;
    wps = 16'h0000;
    swp = '0;
    pw = 32'h5a3c96e1;
    bank_register = 1'b0;
    gix = 4'h0;
    cp = 16'h0000;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_map();
    t_ebus();
    t_be();
    t_prot();
    t_par();
    t_pw();
    t_gpr();
    // idle cycles in a row so the no-request check sees its case
    repeat (3) i_cpu.idle();
    results();
  end
endmodule : tb
`default_nettype wire
